// >>> include/iel_pkg.sv
// Purpose: Shared constants for the interrupt enable and latch logic.
// Assumes: Byte-wide special-function registers with 12-bit addresses.
// Notes:   Source numbers match latch bit numbers (3 to 25).
`default_nettype none
package iel_pkg;
	localparam int          ADDR_W           = 12;
	localparam int          SRC_LO           = 3;
	localparam int          SRC_HI           = 25;
	localparam int          MASK_LO          = 4;
	localparam int          OWN_EN_HI        = 15;
	localparam int          SRC_ID_W         = 5;
	localparam int          WDT_SRC          = 3;
	localparam int          IMF_BIT          = 0;
	localparam int          EN_LOW_FIRST     = 4;
	localparam logic [11:0] ADDR_ENABLE_LOW  = 12'h03a;
	localparam logic [11:0] ADDR_ENABLE_HIGH = 12'h03b;
	localparam logic [11:0] ADDR_LATCH_LOW   = 12'hfe0;
	localparam logic [11:0] ADDR_LATCH_HIGH  = 12'hfe1;
	localparam logic [11:0] ADDR_LATCH_EXT   = 12'hfe2;
	localparam logic [11:0] ADDR_LATCH_TOP   = 12'hfe3;
	localparam logic [7:0]  RST_BYTE         = 8'h00;
	localparam logic        RST_IMF          = 1'b0;
	localparam logic [7:0]  LATCH_LOW_MASK   = 8'hf8;
	localparam logic [7:0]  LATCH_TOP_MASK   = 8'h03;
	localparam logic [7:0]  ENABLE_LOW_MASK  = 8'hf1;
	localparam logic [25:0] RST_PEND         = 26'h0000000;
	localparam logic [25:0] LATCH_SW_CLR_OK  = 26'h3fffff0;
endpackage
`default_nettype wire

// >>> include/iel_latch_if.sv
// Purpose: Carries set, clear and state of the pending latches between modules.
// Assumes: Bits 0 to 2 of every vector are unused and held at zero.
// Notes:   Control side computes masks; bank side holds the flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface iel_latch_if;
	logic [25:0] set_req;
	logic [25:0] sw_clr;
	logic [25:0] ack_clr;
	logic [25:0] pend;
	modport ctl
	(
		output set_req,
		output sw_clr,
		output ack_clr,
		input  pend
	);
	modport bank
	(
		input  set_req,
		input  sw_clr,
		input  ack_clr,
		output pend
	);
endinterface
`default_nettype wire

// >>> rtl/iel_latch.sv
// Purpose: Bank of pending latches for sources 3 to 25.
// Assumes: Set, clear and acceptance masks are one-cycle pulses on i_clk.
// Notes:   A request in the same cycle as a clear of its latch is kept.
`timescale 1ns/1ps
`default_nettype none
module iel_latch
	import iel_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rstn,
	iel_latch_if.bank  lat
);
	logic [25:0] pend_r;
	logic [25:0] pend_nxt;

	always_comb
	begin
		// Clears are applied first so that a new request wins over them.
		pend_nxt = (pend_r & ~(lat.sw_clr | lat.ack_clr)) | lat.set_req;
		pend_nxt[SRC_LO-1:0] = '0;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pend_r <= RST_PEND;
		else
			pend_r <= pend_nxt;
	end

	assign lat.pend = pend_r;
endmodule
`default_nettype wire

// >>> rtl/iel_top.sv
// Purpose: Master flag, per-source enables and pending latches for maskable interrupts.
// Assumes: Requests, acceptance and instruction events come from logic on i_clk.
// Notes:   Vector selection and priority levels live in the core outside this block.
`timescale 1ns/1ps
`default_nettype none
module iel_top
	import iel_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_rstn,
	input  wire logic [ADDR_W-1:0]   i_sfr_addr,
	input  wire logic                i_sfr_wr,
	input  wire logic                i_sfr_rd,
	input  wire logic                i_sfr_word,
	input  wire logic [15:0]         i_sfr_wdata,
	input  wire logic [25:0]         i_src_req,
	input  wire logic [25:16]        i_ext_enable,
	input  wire logic                i_accept,
	input  wire logic [SRC_ID_W-1:0] i_accept_src,
	input  wire logic                i_return,
	input  wire logic                i_stack_imf,
	input  wire logic                i_set_master_instr,
	input  wire logic                i_clear_master_instr,
	output logic [15:0]              o_sfr_rdata,
	output logic                     o_sfr_rvalid,
	output logic                     o_master_accept_flag,
	output logic                     o_saved_imf,
	output logic                     o_saved_valid,
	output logic [25:0]              o_offer,
	output logic                     o_maskable_req,
	output logic                     o_watchdog_req,
	output logic [25:0]              o_pending
);
	iel_latch_if lat ();

	logic                  imf_r;
	logic                  imf_nxt;
	logic [OWN_EN_HI:0]    en_r;
	logic [OWN_EN_HI:0]    en_nxt;
	logic [25:0]           en_all;
	logic [25:0]           offer_nxt;
	logic [25:0]           sw_clr_nxt;
	logic                  wr_en_low;
	logic                  wr_en_high;
	logic [7:0]            data_en_low;
	logic [7:0]            data_en_high;

	// True when the current byte or word access touches the given byte target.
	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic word,
		input logic [ADDR_W-1:0] target);
		logic [ADDR_W-1:0] next_addr;
		next_addr = addr + 12'h001;
		hits = (addr == target) || (word && next_addr == target);
	endfunction

	// Data byte carried for a target: the high byte when the target is the second one.
	function automatic logic [7:0] data_for(input logic [ADDR_W-1:0] addr,
		input logic [15:0] wdata, input logic [ADDR_W-1:0] target);
		data_for = (addr == target) ? wdata[7:0] : wdata[15:8];
	endfunction

	// Byte view of every register; unmapped addresses and unused bits read as 0.
	function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] addr,
		input logic master_accept_flag, input logic [OWN_EN_HI:0] en, input logic [25:0] pend);
		logic [7:0] b;
		b = RST_BYTE;
		unique case (addr)
			ADDR_ENABLE_LOW:  b = {en[7:4], 3'h0, master_accept_flag};
			ADDR_ENABLE_HIGH: b = en[15:8];
			ADDR_LATCH_LOW:   b = pend[7:0] & LATCH_LOW_MASK;
			ADDR_LATCH_HIGH:  b = pend[15:8];
			ADDR_LATCH_EXT:   b = pend[23:16];
			ADDR_LATCH_TOP:   b = {6'h00, pend[25:24]};
			default:          b = RST_BYTE;
		endcase
		read_byte = b;
	endfunction

	// One-hot mask of the source taken by the core; sources below 3 have no latch.
	function automatic logic [25:0] src_mask(input logic [SRC_ID_W-1:0] src);
		logic [25:0] m;
		m = '0;
		if (src >= 5'(SRC_LO) && src <= 5'(SRC_HI))
			m[src] = 1'b1;
		src_mask = m;
	endfunction

	// Turns a written byte into clear bits: a 0 clears, a 1 leaves the latch.
	function automatic logic [7:0] clr_bits(input logic [7:0] data, input logic [7:0] usable);
		clr_bits = ~data & usable;
	endfunction

	assign wr_en_low    = i_sfr_wr && hits(i_sfr_addr, i_sfr_word, ADDR_ENABLE_LOW);
	assign wr_en_high   = i_sfr_wr && hits(i_sfr_addr, i_sfr_word, ADDR_ENABLE_HIGH);
	assign data_en_low  = data_for(i_sfr_addr, i_sfr_wdata, ADDR_ENABLE_LOW);
	assign data_en_high = data_for(i_sfr_addr, i_sfr_wdata, ADDR_ENABLE_HIGH);

	// Master flag: acceptance beats a return, which beats instructions and writes.
	always_comb
	begin
		imf_nxt = imf_r;
		if (i_accept)
			imf_nxt = 1'b0;
		else if (i_return)
			imf_nxt = i_stack_imf;
		else if (i_clear_master_instr)
			imf_nxt = 1'b0;
		else if (i_set_master_instr)
			imf_nxt = 1'b1;
		else if (wr_en_low)
			imf_nxt = data_en_low[IMF_BIT];
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			imf_r <= RST_IMF;
		else
			imf_r <= imf_nxt;
	end

	// The value pushed to the stack is the flag as it stood before acceptance.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_saved_imf   <= RST_IMF;
			o_saved_valid <= 1'b0;
		end
		else
		begin
			o_saved_valid <= i_accept;
			if (i_accept)
				o_saved_imf <= imf_r;
		end
	end

	// Enable flags; bits 3 to 0 of the vector carry no enable and stay 0.
	always_comb
	begin
		en_nxt = en_r;
		if (wr_en_low)
			en_nxt[7:EN_LOW_FIRST] = data_en_low[7:EN_LOW_FIRST];
		if (wr_en_high)
			en_nxt[15:8] = data_en_high;
		en_nxt[EN_LOW_FIRST-1:0] = '0;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			en_r <= '0;
		else
			en_r <= en_nxt;
	end

	// Software clears: only bits that exist and are writable, never the watchdog latch.
	always_comb
	begin
		sw_clr_nxt = '0;
		if (i_sfr_wr)
		begin
			if (hits(i_sfr_addr, i_sfr_word, ADDR_LATCH_LOW))
				sw_clr_nxt[7:0] = clr_bits(data_for(i_sfr_addr, i_sfr_wdata, ADDR_LATCH_LOW),
					LATCH_LOW_MASK);
			if (hits(i_sfr_addr, i_sfr_word, ADDR_LATCH_HIGH))
				sw_clr_nxt[15:8] = clr_bits(data_for(i_sfr_addr, i_sfr_wdata, ADDR_LATCH_HIGH),
					8'hff);
			if (hits(i_sfr_addr, i_sfr_word, ADDR_LATCH_EXT))
				sw_clr_nxt[23:16] = clr_bits(data_for(i_sfr_addr, i_sfr_wdata, ADDR_LATCH_EXT),
					8'hff);
			if (hits(i_sfr_addr, i_sfr_word, ADDR_LATCH_TOP))
				sw_clr_nxt[25:24] = 2'(clr_bits(data_for(i_sfr_addr, i_sfr_wdata, ADDR_LATCH_TOP),
					LATCH_TOP_MASK));
		end
		sw_clr_nxt = sw_clr_nxt & LATCH_SW_CLR_OK;
	end

	assign lat.sw_clr  = sw_clr_nxt;
	assign lat.ack_clr = i_accept ? src_mask(i_accept_src) : '0;
	assign lat.set_req = {i_src_req[25:SRC_LO], {SRC_LO{1'b0}}};

	iel_latch u_latch
	(
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.lat    (lat)
	);

	assign en_all = {i_ext_enable, en_r};

	// Each maskable latch is offered only under the master flag and its own enable.
	always_comb
	begin
		offer_nxt = lat.pend & en_all & {26{imf_r}};
		offer_nxt[MASK_LO-1:0] = '0;
		// The watchdog latch is offered regardless of any flag.
		offer_nxt[WDT_SRC] = lat.pend[WDT_SRC];
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_offer        <= '0;
			o_maskable_req <= 1'b0;
			o_watchdog_req <= 1'b0;
		end
		else
		begin
			o_offer        <= offer_nxt;
			o_maskable_req <= |offer_nxt[SRC_HI:MASK_LO];
			o_watchdog_req <= lat.pend[WDT_SRC];
		end
	end

	// Outputs lag the flops by one cycle, which keeps every output registered.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_master_accept_flag <= RST_IMF;
			o_pending            <= RST_PEND;
		end
		else
		begin
			o_master_accept_flag <= imf_r;
			o_pending            <= lat.pend;
		end
	end

	// Reads return state from before any write in the same cycle.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_sfr_rdata  <= '0;
			o_sfr_rvalid <= 1'b0;
		end
		else
		begin
			o_sfr_rvalid <= i_sfr_rd;
			if (i_sfr_rd)
			begin
				o_sfr_rdata[7:0]  <= read_byte(i_sfr_addr, imf_r, en_r, lat.pend);
				o_sfr_rdata[15:8] <= i_sfr_word ?
					read_byte(i_sfr_addr + 12'h001, imf_r, en_r, lat.pend) : 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/iel_assertions.sv
// Purpose: Port-level assertions for the interrupt enable and latch block.
// Assumes: Single clock domain with asynchronous active-low reset.
// Notes:   Attached to every instance of the top module by bind.
`timescale 1ns/1ps
`default_nettype none
module iel_top_checker
	import iel_pkg::*;
(
	input wire logic              i_clk,
	input wire logic              i_rstn,
	input wire logic [ADDR_W-1:0] i_sfr_addr,
	input wire logic              i_sfr_rd,
	input wire logic              i_sfr_word,
	input wire logic [25:0]       i_src_req,
	input wire logic              i_accept,
	input wire logic              i_return,
	input wire logic              i_stack_imf,
	input wire logic              i_set_master_instr,
	input wire logic              i_clear_master_instr,
	input wire logic [15:0]       o_sfr_rdata,
	input wire logic              o_sfr_rvalid,
	input wire logic              o_master_accept_flag,
	input wire logic              o_saved_valid,
	input wire logic [25:0]       o_offer,
	input wire logic              o_maskable_req,
	input wire logic              o_watchdog_req,
	input wire logic [25:0]       o_pending
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_read_answer: assert property (o_sfr_rvalid == $past(i_sfr_rd))
		else $error("read answer out of step");
	a_latch_low_read: assert property ($past(i_sfr_rd) && !$past(i_sfr_word) && $past(i_sfr_addr) == 12'hfe0
		|-> o_sfr_rdata == {8'h00, o_pending[7:3], 3'b000}) else $error("low latch byte wrong");
	a_accept_saves: assert property (i_accept |=> o_saved_valid ##1 !o_master_accept_flag)
		else $error("accept did not save and clear flag");
	a_return_restores: assert property (i_return && !i_accept |-> ##2 o_master_accept_flag == $past(i_stack_imf, 2))
		else $error("return did not restore flag");
	a_set_instr: assert property (i_set_master_instr && !(i_accept || i_return || i_clear_master_instr)
		|-> ##2 o_master_accept_flag) else $error("set instruction ignored");
	a_clear_instr: assert property (i_clear_master_instr && !(i_accept || i_return) |-> ##2 !o_master_accept_flag)
		else $error("clear instruction ignored");
	a_offer_gated: assert property (|o_offer[25:4] |-> o_master_accept_flag && (o_offer & ~o_pending) == 26'h0)
		else $error("offer without flag or latch");
	a_watchdog_free: assert property (o_watchdog_req == o_pending[3] && o_offer[3:0] == {o_pending[3], 3'b000})
		else $error("watchdog offer wrong");
	a_maskable_any: assert property (o_maskable_req == |o_offer[25:4])
		else $error("maskable request mismatch");
	a_request_latches: assert property (|i_src_req[25:3] |-> ##2
		(o_pending[25:3] & $past(i_src_req[25:3], 2)) == $past(i_src_req[25:3], 2)) else $error("request not latched");
endmodule
bind iel_top iel_top_checker u_chk (.i_clk, .i_rstn, .i_sfr_addr, .i_sfr_rd, .i_sfr_word, .i_src_req, .i_accept,
	.i_return, .i_stack_imf, .i_set_master_instr, .i_clear_master_instr, .o_sfr_rdata, .o_sfr_rvalid,
	.o_master_accept_flag, .o_saved_valid, .o_offer, .o_maskable_req, .o_watchdog_req, .o_pending);
`default_nettype wire

// >>> tb/iel_core_model.sv
// Purpose: Behavioural core that accepts offered interrupts and returns.
// Assumes: Offer and saved flag come from the block on the same clock.
// Notes:   Handler length set by i_delay, so prompt and slow returns occur.
`timescale 1ns/1ps
`default_nettype none
module iel_core_model
	import iel_pkg::*;
(
	input  wire logic           i_clk,
	input  wire logic           i_go,
	input  wire logic [3:0]     i_delay,
	input  wire logic [25:0]    i_offer,
	input  wire logic           i_saved_imf,
	output logic                o_accept,
	output logic [SRC_ID_W-1:0] o_accept_src,
	output logic                o_return,
	output logic                o_stack_imf,
	output int                  o_taken
);
	logic                stk;
	logic [SRC_ID_W-1:0] pick;
	initial
	begin
		{o_accept, o_accept_src, o_return, o_stack_imf} = '0;
		o_taken = 0;
		forever
		begin
			@(posedge i_clk);
			if (i_go && |i_offer[25:3])
			begin
				pick = '0;
				for (int n = 3; n < 26; n++)
					if (i_offer[n])
						pick = n[SRC_ID_W-1:0];
				o_accept_src <= pick;
				o_accept <= 1'b1;
				@(posedge i_clk);
				o_accept <= 1'b0;
				o_accept_src <= ~o_accept_src;
				// The saved flag lands on the accept edge, so it is read one edge later.
				@(posedge i_clk);
				stk = i_saved_imf;
				// The handler touches no flag or latch, so nothing changes before the flag returns.
				repeat (i_delay) @(posedge i_clk);
				o_return <= 1'b1;
				o_stack_imf <= stk;
				o_taken <= o_taken + 1;
				@(posedge i_clk);
				o_return <= 1'b0;
				o_stack_imf <= ~stk;
				repeat (3) @(posedge i_clk);
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/iel_top_tb.sv
// Purpose: Self-checking bench for the interrupt enable and latch block.
// Assumes: A core model answers acceptance; the bench plays software.
// Notes:   A shadow of flags and latches gives every expected register, latch and flag value.
`timescale 1ns/1ps
`default_nettype none
module iel_top_tb
	import iel_pkg::*;
;
	logic              i_clk = 1'b0, i_rstn = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_sfr_word = 1'b0;
	logic              i_set_master_instr = 1'b0, i_clear_master_instr = 1'b0, go = 1'b0;
	logic              i_accept, i_return, i_stack_imf, o_sfr_rvalid, o_master_accept_flag;
	logic              o_saved_imf, o_saved_valid, o_maskable_req, o_watchdog_req;
	logic [4:0]        i_accept_src;
	logic [11:0]       i_sfr_addr = '0;
	logic [15:0]       i_sfr_wdata = '0, o_sfr_rdata, m_en = '0;
	logic [25:0]       i_src_req = '0, o_offer, o_pending;
	logic [25:16]      i_ext_enable = '0;
	logic [31:0]       m_p = '0;
	logic [3:0]        delay = '0;
	int                mismatches = 0, compares = 0, taken;
	logic [11:0]       addrs [8] = '{12'h03a, 12'h03b, 12'hfe0, 12'hfe1, 12'hfe2, 12'hfe3, 12'h03c, 12'hfe4};
	iel_top u_dut (.i_clk, .i_rstn, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_word, .i_sfr_wdata, .i_src_req,
		.i_ext_enable, .i_accept, .i_accept_src, .i_return, .i_stack_imf, .i_set_master_instr,
		.i_clear_master_instr, .o_sfr_rdata, .o_sfr_rvalid, .o_master_accept_flag, .o_saved_imf,
		.o_saved_valid, .o_offer, .o_maskable_req, .o_watchdog_req, .o_pending);
	iel_core_model u_core (.i_clk, .i_go(go), .i_delay(delay), .i_offer(o_offer), .i_saved_imf(o_saved_imf),
		.o_accept(i_accept), .o_accept_src(i_accept_src), .o_return(i_return), .o_stack_imf(i_stack_imf),
		.o_taken(taken));
	initial
		forever #25 i_clk = ~i_clk;
	task automatic print_verdict();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [11:0] a);
		if (a == 12'h03a || a == 12'h03b)
			return m_en[8*a[0] +: 8];
		if (a[11:2] == 10'h3f8)
			return m_p[8*a[1:0] +: 8];
		return 8'h00;
	endfunction
	// Latch writes only clear; bit 3 and the unused bits are never writable.
	task automatic mwr(input logic [11:0] a, input logic [7:0] v);
		if (a == 12'h03a)
			m_en[7:0] = v & 8'hf1;
		if (a == 12'h03b)
			m_en[15:8] = v;
		if (a[11:2] == 10'h3f8)
			m_p[8*a[1:0] +: 8] &= v | ~(32'h03fffff0 >> (8*a[1:0]));
	endtask
	task automatic op(input int k, input logic [11:0] a, input logic [25:0] d);
		@(posedge i_clk);
		i_sfr_addr <= a;
		i_sfr_wdata <= d[15:0];
		i_sfr_word <= (k == 1) || (k == 6);
		i_sfr_wr <= (k < 2);
		i_src_req <= (k == 2) ? d : 26'h0;
		i_set_master_instr <= (k == 3);
		i_clear_master_instr <= (k == 4);
		i_sfr_rd <= (k >= 5);
		@(posedge i_clk);
		{i_sfr_wr, i_sfr_rd, i_set_master_instr, i_clear_master_instr} <= 4'h0;
		i_src_req <= 26'h0;
		i_sfr_addr <= ~a;
		if (k < 2)
			mwr(a, d[7:0]);
		if (k == 1)
			mwr(a + 12'h1, d[15:8]);
		if (k == 2)
			m_p |= {6'h0, d & 26'h3fffff8};
		if (k == 3 || k == 4)
			m_en[0] = (k == 3);
		if (k >= 5)
		begin
			@(negedge i_clk);
			cmp({o_sfr_rvalid, o_sfr_rdata}, {1'b1, (k == 6) ? exp_rd(a + 12'h1) : 8'h00, exp_rd(a)});
		end
	endtask
	task automatic chk_out();
		logic [25:0] e;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		e = m_p[25:0] & {{i_ext_enable, m_en[15:4]} & {22{m_en[0]}}, 4'h8};
		cmp(o_pending, m_p[25:0]);
		cmp(o_offer, e);
		cmp(o_maskable_req, |e[25:4]);
		cmp(o_watchdog_req, m_p[3]);
		cmp(o_master_accept_flag, m_en[0]);
	endtask
	task automatic chk_all();
		foreach (addrs[j])
			op(5, addrs[j], 0);
		chk_out();
	endtask
	task automatic do_reset();
		@(posedge i_clk);
		i_rstn <= 1'b0;
		m_en = '0;
		m_p = '0;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
	endtask
	task automatic take(input logic [3:0] dly, input int src);
		int n0;
		n0 = taken;
		@(posedge i_clk);
		go <= 1'b1;
		delay <= dly;
		repeat (100)
			if (taken == n0)
				@(posedge i_clk);
		go <= 1'b0;
		cmp(taken, n0 + 1);
		cmp(o_saved_imf, m_en[0]);
		m_p[src] = 1'b0;
		chk_all();
	endtask
	initial
	begin
		int k;
		void'($urandom(32'h469b41d1));
		do_reset();
		chk_all();
		$display("test reset_values done");
		op(2, 0, 26'h3fffff8);
		op(0, 12'h03a, 26'hff);
		op(0, 12'hfe0, 26'h0);
		op(0, 12'hfe3, 26'hfc);
		op(1, 12'hfe1, 26'hff00);
		chk_all();
		$display("test corners done");
		repeat (80)
		begin
			k = $urandom_range(6);
			@(posedge i_clk);
			i_ext_enable <= 10'($urandom);
			if (k < 2)
				op(4, 0, 0);
			op(k, addrs[$urandom_range(7)], 26'($urandom));
			op(5, addrs[$urandom_range(7)], 0);
			chk_out();
		end
		$display("test random done");
		do_reset();
		chk_all();
		op(1, 12'h03a, 26'h0020);
		op(3, 0, 0);
		op(2, 0, 26'h20);
		take(0, 5);
		op(4, 0, 0);
		op(2, 0, 26'h8);
		take(9, 3);
		$display("test accept done");
		print_verdict();
	end
	initial
	begin
		#(50 * 8000);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
